// ===== logic/rtot_cfg.svh
// Register offsets, field positions, reset values and counts of the reload timer.
`ifndef RTOT_CFG_SVH
`define RTOT_CFG_SVH
`define RTOT_ADR_CTRL 8'h00
`define RTOT_ADR_COUNT 8'h04
`define RTOT_ADR_RELOAD 8'h08
`define RTOT_ADR_MATCH 8'h0C
`define RTOT_ADR_STATUS 8'h10
`define RTOT_CTRL_EN 0
`define RTOT_CTRL_MODE 1
`define RTOT_CTRL_PSC 3
`define RTOT_CTRL_POL 6
`define RTOT_CTRL_OE 7
`define RTOT_CNT_RST 16'h0000
`define RTOT_RELOAD_RST 16'h0000
`define RTOT_MATCH_RST 16'h0000
`define RTOT_CNT_RESTART 16'h0001
`define RTOT_CNT_MAX 16'hFFFF
`define RTOT_PSC_W 3
`define RTOT_PSC_CNT_W 7
`endif

// ===== logic/rtot_pkg.sv
// Types shared by the reload timer.
package rtot_pkg;
   typedef enum logic [1:0]
   {
      RTOT_ONESHOT = 2'h0,
      RTOT_CONT = 2'h1,
      RTOT_COUNTER = 2'h3,
      RTOT_PWM = 2'h2
   } rtot_mode_t;
endpackage

// ===== logic/rtot_timer.sv
// Reload timer with one-shot, continuous, counter and PWM modes behind a Wishbone slave.
`timescale 1ns/1ps
`include "rtot_cfg.svh"

module rtot_timer
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic timer_in_i,
   output logic timer_out_o,
   output logic timer_out_en_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------

   logic ack_r;
   logic [31:0] dat_r;
   logic wr;
   logic en_r;
   rtot_pkg::rtot_mode_t mode_r;
   logic [`RTOT_PSC_W-1:0] psc_r;
   logic pol_r;
   logic oe_r;
   logic [15:0] cnt_r;
   logic [15:0] reload_r;
   logic [15:0] match_r;
   logic level_r;
   logic pulse_r;

   // Merges the low two byte lanes of a write into a 16-bit register.
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [15:0] m;
      m = old;
      if (s[0])
      begin
         m[7:0] = d[7:0];
      end
      if (s[1])
      begin
         m[15:8] = d[15:8];
      end
      return m;
   endfunction

   // A write takes effect at the edge on which ack is seen high.
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      end
   end

   // Unmapped addresses read as zero and ignore writes.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dat_r <= 32'h0000_0000;
      end
      else if (wb_cyc_i && wb_stb_i && !ack_r)
      begin
         if (wb_adr_i == `RTOT_ADR_CTRL)
         begin
            dat_r <= {24'h00_0000, oe_r, pol_r, psc_r, mode_r, en_r};
         end
         else if (wb_adr_i == `RTOT_ADR_COUNT)
         begin
            dat_r <= {16'h0000, cnt_r};
         end
         else if (wb_adr_i == `RTOT_ADR_RELOAD)
         begin
            dat_r <= {16'h0000, reload_r};
         end
         else if (wb_adr_i == `RTOT_ADR_MATCH)
         begin
            dat_r <= {16'h0000, match_r};
         end
         else if (wb_adr_i == `RTOT_ADR_STATUS)
         begin
            dat_r <= {30'h0000_0000, timer_out_o, en_r};
         end
         else
         begin
            dat_r <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control and data registers
   // ----------------------------------------------------------------

   logic wr_ctrl;
   logic wr_cnt;
   logic start;
   logic tick;
   logic reach;
   logic [15:0] cnt_inc;

   assign wr_ctrl = wr && wb_adr_i == `RTOT_ADR_CTRL && wb_sel_i[0];
   assign wr_cnt = wr && wb_adr_i == `RTOT_ADR_COUNT;
   assign start = wr_ctrl && wb_dat_i[`RTOT_CTRL_EN] && !en_r;
   assign cnt_inc = cnt_r + 16'h0001;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode_r <= rtot_pkg::RTOT_ONESHOT;
         psc_r <= 3'h0;
         pol_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         mode_r <= rtot_pkg::rtot_mode_t'(wb_dat_i[`RTOT_CTRL_MODE +: 2]);
         psc_r <= wb_dat_i[`RTOT_CTRL_PSC +: `RTOT_PSC_W];
         pol_r <= wb_dat_i[`RTOT_CTRL_POL];
         oe_r <= wb_dat_i[`RTOT_CTRL_OE];
      end
   end

   // A software write wins over the one-shot self-disable in the same cycle.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en_r <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         en_r <= wb_dat_i[`RTOT_CTRL_EN];
      end
      else if (reach && mode_r == rtot_pkg::RTOT_ONESHOT)
      begin
         en_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         reload_r <= `RTOT_RELOAD_RST;
         match_r <= `RTOT_MATCH_RST;
      end
      else if (wr && wb_adr_i == `RTOT_ADR_RELOAD)
      begin
         reload_r <= merge16(reload_r, wb_dat_i, wb_sel_i);
      end
      else if (wr && wb_adr_i == `RTOT_ADR_MATCH)
      begin
         match_r <= merge16(match_r, wb_dat_i, wb_sel_i);
      end
   end

   // ----------------------------------------------------------------
   // Count sources
   // ----------------------------------------------------------------

   logic [`RTOT_PSC_CNT_W-1:0] presc_r;
   logic [`RTOT_PSC_CNT_W-1:0] presc_lim;
   logic in_s1_r;
   logic in_s2_r;
   logic in_s3_r;
   logic edge_hit;

   // Divide by 2 to the power of the prescale field, from 1 to 128.
   assign presc_lim = `RTOT_PSC_CNT_W'((8'h01 << psc_r) - 8'h01);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         presc_r <= 7'h00;
      end
      else if (!en_r || presc_r == presc_lim)
      begin
         presc_r <= 7'h00;
      end
      else
      begin
         presc_r <= presc_r + 7'h01;
      end
   end

   // The pin is synchronised before edge detection; slow inputs are assumed.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         in_s1_r <= 1'b0;
         in_s2_r <= 1'b0;
         in_s3_r <= 1'b0;
      end
      else
      begin
         in_s1_r <= timer_in_i;
         in_s2_r <= in_s1_r;
         in_s3_r <= in_s2_r;
      end
   end

   // Polarity 1 counts rising edges, polarity 0 falling edges.
   assign edge_hit = (in_s2_r != in_s3_r) && (in_s2_r == pol_r);

   always_comb
   begin
      if (!en_r)
      begin
         tick = 1'b0;
      end
      else if (mode_r == rtot_pkg::RTOT_COUNTER)
      begin
         tick = edge_hit;
      end
      else
      begin
         tick = presc_r == presc_lim;
      end
   end

   // The count arriving at the reload value is the time-out event.
   assign reach = tick && cnt_r != reload_r && cnt_inc == reload_r;

   // ----------------------------------------------------------------
   // Counter and output
   // ----------------------------------------------------------------

   // After a time-out the count shows reload for one step, then restarts at 0001h; in one-shot mode it goes straight to 0001h.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_r <= `RTOT_CNT_RST;
      end
      else if (wr_cnt)
      begin
         cnt_r <= merge16(cnt_r, wb_dat_i, wb_sel_i);
      end
      else if (reach && mode_r == rtot_pkg::RTOT_ONESHOT)
      begin
         cnt_r <= `RTOT_CNT_RESTART;
      end
      else if (tick && cnt_r == reload_r)
      begin
         cnt_r <= `RTOT_CNT_RESTART;
      end
      else if (tick)
      begin
         cnt_r <= cnt_inc;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_o <= 1'b0;
      end
      else
      begin
         irq_o <= reach;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         level_r <= 1'b0;
      end
      else if (start)
      begin
         level_r <= wb_dat_i[`RTOT_CTRL_POL];
      end
      else if (mode_r == rtot_pkg::RTOT_ONESHOT)
      begin
         level_r <= pol_r;
      end
      else if (mode_r == rtot_pkg::RTOT_PWM && reach)
      begin
         level_r <= pol_r;
      end
      else if (mode_r == rtot_pkg::RTOT_PWM && tick && cnt_inc == match_r)
      begin
         level_r <= !pol_r;
      end
      else if (reach && oe_r)
      begin
         level_r <= !level_r;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pulse_r <= 1'b0;
      end
      else
      begin
         pulse_r <= reach && oe_r && mode_r == rtot_pkg::RTOT_ONESHOT;
      end
   end

   assign timer_out_o = level_r ^ pulse_r;
   assign timer_out_en_o = oe_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence oneshot_hit_s;
      reach && mode_r == rtot_pkg::RTOT_ONESHOT && !wr_ctrl && !wr_cnt;
   endsequence

   sequence restart_s;
      tick && cnt_r == reload_r && !wr_cnt;
   endsequence

   oneshot_stop_a: assert property (oneshot_hit_s |=> !en_r && cnt_r == 16'h0001)
      else $error("one-shot did not stop at 0001h");
   pulse_width_a: assert property (pulse_r |=> !pulse_r && timer_out_o == level_r)
      else $error("one-shot output pulse not one cycle");
   restart_one_a: assert property (restart_s |=> cnt_r == 16'h0001)
      else $error("count did not restart at 0001h");
   wrap_zero_a: assert property (tick && cnt_r == 16'hFFFF && reload_r != 16'hFFFF && reload_r != 16'h0000 && !wr_cnt
      |=> cnt_r == 16'h0000)
      else $error("count did not wrap to 0000h");
   hold_off_a: assert property (!en_r && !wr_cnt |=> $stable(cnt_r) && !irq_o)
      else $error("count moved while disabled");
   irq_cause_a: assert property (irq_o |-> $past(en_r) && $past(cnt_r) != $past(reload_r))
      else $error("interrupt without reload");
   pwm_match_a: assert property (mode_r == rtot_pkg::RTOT_PWM && tick && cnt_inc == match_r && !reach
      && !start |=> level_r == !pol_r)
      else $error("pwm output missed match");
   pwm_reload_a: assert property (mode_r == rtot_pkg::RTOT_PWM && reach && !start |=> level_r == pol_r)
      else $error("pwm output missed reload");
   counter_edge_a: assert property (en_r && mode_r == rtot_pkg::RTOT_COUNTER && tick
      |-> in_s2_r == pol_r && in_s3_r != pol_r)
      else $error("counter step without selected edge");
   presc_one_a: assert property (en_r && mode_r != rtot_pkg::RTOT_COUNTER && psc_r == 3'h0 |-> tick)
      else $error("prescale 1 missed a step");

endmodule

// ===== verification/rtot_pin_model.sv
// Model of the GPIO pin that feeds the timer input with a paced burst of transitions.
`timescale 1ns/1ps

module rtot_pin_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [7:0] n_i,
   output logic pin_o,
   output logic busy_o
);
   logic [7:0] left_r;
   logic [1:0] gap_r;

   // Transitions come four clocks apart, so the pin stays within a quarter of the clock rate.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         left_r <= 8'h00;
         gap_r <= 2'h0;
         pin_o <= 1'b0;
      end
      else if (go_i && left_r == 8'h00)
      begin
         left_r <= n_i;
         gap_r <= 2'h0;
      end
      else if (left_r != 8'h00)
      begin
         gap_r <= gap_r + 2'h1;
         if (gap_r == 2'h3)
         begin
            pin_o <= ~pin_o;
            left_r <= left_r - 8'h01;
         end
      end
   end

   assign busy_o = (left_r != 8'h00);
endmodule

// ===== verification/rtot_timer_tb.sv
// Self-checking testbench of the reload timer.
`timescale 1ns/1ps
`include "rtot_cfg.svh"
`define CHK(g, e) chk(32'(g), 32'(e))

module reload_timer_oneshot_cont_count_pwm_tb_top;
   localparam logic [7:0] a_ctl = `RTOT_ADR_CTRL;
   localparam logic [7:0] a_cnt = `RTOT_ADR_COUNT;
   localparam logic [7:0] a_sts = `RTOT_ADR_STATUS;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h3;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic pin;
   logic timer_out;
   logic timer_out_en;
   logic irq;
   logic go = 1'b0;
   logic [7:0] n = 8'h00;
   logic busy;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   int irq_cnt = 0;

   rtot_timer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .timer_in_i(pin), .timer_out_o(timer_out), .timer_out_en_o(timer_out_en), .irq_o(irq));
   rtot_pin_model pins (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .n_i(n), .pin_o(pin), .busy_o(busy));

   initial
   begin
      forever #4 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
   begin
      cycles++;
      if (irq === 1'b1)
         irq_cnt++;
      if (cycles == 6000)
      begin
         n_fail++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   function automatic logic [31:0] ctl(logic en, rtot_pkg::rtot_mode_t m, logic [2:0] ps, logic pl, logic oe);
      return {24'h000000, oe, pl, ps, m, en};
   endfunction

   // ----------------------------------------
   // Bus cycles and pin helpers
   // ----------------------------------------
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= d;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end while (wb_ack !== 1'b1 && k < 50);
      `CHK(wb_ack, 1'b1);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      `CHK(q, e);
   endtask

   task automatic setup(input logic [31:0] c, input logic [15:0] s, input logic [15:0] r, input logic [15:0] m);
      wr(a_ctl, c);
      wr(a_cnt, 32'(s));
      wr(`RTOT_ADR_MATCH, 32'(m));
      wr(`RTOT_ADR_RELOAD, 32'(r));
   endtask

   task automatic wait_irq(output int k);
      k = 0;
      do
      begin
         @(posedge clk_i);
         #1;
         k++;
      end while (irq !== 1'b1 && k < 400);
      `CHK(irq, 1'b1);
   endtask

   task automatic pin_go(input logic [7:0] cnt);
      go <= 1'b1;
      n <= cnt;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic pin_wait();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 500)
      begin
         @(posedge clk_i);
         k++;
      end
      repeat (5) @(posedge clk_i);
   endtask

   task automatic off_chk();
      int c;
      wr(a_ctl, 32'h0);
      c = irq_cnt;
      repeat (20) @(posedge clk_i);
      `CHK(irq_cnt, c);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd_chk(a_ctl, 32'h0);
      rd_chk(a_cnt, 32'h0);
      wr(`RTOT_ADR_RELOAD, 32'hABCD1234);
      rd_chk(`RTOT_ADR_RELOAD, 32'h1234);
      wr(8'h14, 32'hFF);
      rd_chk(8'h14, 32'h0);
      wr(a_sts, 32'hFF);
      rd_chk(a_sts, 32'h0);
   endtask

   task automatic t_os(input logic p);
      int k;
      int c;
      setup(ctl(1'b0, rtot_pkg::RTOT_ONESHOT, 3'h0, 1'b0, 1'b1), 16'h0001, 16'h0014, 16'h0000);
      c = irq_cnt;
      wr(a_ctl, ctl(1'b1, rtot_pkg::RTOT_ONESHOT, 3'h0, 1'b0, 1'b1));
      if (p)
         wr(a_ctl, ctl(1'b1, rtot_pkg::RTOT_ONESHOT, 3'h0, 1'b1, 1'b1));
      wait_irq(k);
      `CHK(k, p ? 14 : 18);
      `CHK(timer_out, !p);
      @(posedge clk_i);
      #1;
      `CHK(timer_out, p);
      rd_chk(a_sts, {30'h0, p, 1'b0});
      rd_chk(a_cnt, 32'h1);
      `CHK(irq_cnt - c, 1);
   endtask

   task automatic t_cont(input logic [2:0] ps, input logic [15:0] s, input logic [15:0] r, input bit first);
      int k1;
      int k2;
      logic o1;
      setup(ctl(1'b0, rtot_pkg::RTOT_CONT, ps, 1'b0, 1'b1), s, r, 16'h0000);
      pin_go(8'd40);
      wr(a_ctl, ctl(1'b1, rtot_pkg::RTOT_CONT, ps, 1'b0, 1'b1));
      wait_irq(k1);
      o1 = timer_out;
      if (first)
         `CHK(k1, (32'(16'(r - s)) << ps) - 1);
      wait_irq(k2);
      `CHK(k2, 32'(r) << ps);
      `CHK(timer_out, !o1);
      off_chk();
   endtask

   task automatic t_counter();
      int c;
      pin_wait();
      setup(ctl(1'b0, rtot_pkg::RTOT_COUNTER, 3'h7, 1'b1, 1'b1), 16'h0001, 16'h0003, 16'h0000);
      c = irq_cnt;
      wr(a_ctl, ctl(1'b1, rtot_pkg::RTOT_COUNTER, 3'h7, 1'b1, 1'b1));
      `CHK(timer_out, 1'b1);
      pin_go(8'd3);
      pin_wait();
      rd_chk(a_cnt, 32'h3);
      `CHK(irq_cnt - c, 1);
      `CHK({timer_out_en, timer_out}, 2'b10);
      setup(ctl(1'b0, rtot_pkg::RTOT_COUNTER, 3'h7, 1'b0, 1'b0), 16'h0001, 16'h0064, 16'h0000);
      pin_go(8'd3);
      pin_wait();
      rd_chk(a_cnt, 32'h1);
      wr(a_ctl, ctl(1'b1, rtot_pkg::RTOT_COUNTER, 3'h7, 1'b0, 1'b0));
      `CHK({timer_out_en, timer_out}, 2'b00);
      pin_go(8'd3);
      pin_wait();
      rd_chk(a_cnt, 32'h2);
      off_chk();
   endtask

   task automatic t_pwm(input logic p);
      int k;
      int h;
      setup(ctl(1'b0, rtot_pkg::RTOT_PWM, 3'h0, p, 1'b1), 16'h0001, 16'h0006, 16'h0004);
      wr(a_ctl, ctl(1'b1, rtot_pkg::RTOT_PWM, 3'h0, p, 1'b1));
      `CHK(timer_out, p);
      wait_irq(k);
      h = 0;
      repeat (6)
      begin
         @(posedge clk_i);
         #1;
         h += timer_out;
      end
      `CHK(h, p ? 4 : 2);
      off_chk();
   endtask

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_os(1'b0);
      t_os(1'b1);
      t_cont(3'h0, 16'hFFFE, 16'h0002, 1'b1);
      t_cont(3'h7, 16'h0001, 16'h0002, 1'b0);
      t_counter();
      t_pwm(1'b1);
      t_pwm(1'b0);
      end_sim();
   end
endmodule
